// file: shared/prb_pkg.sv
// constants shared by the pid regulator block files
package prb_pkg;

   // ==========================================================
   // number format: normalized values are unsigned, 1.0 = 8000
   // ==========================================================
   localparam int          NORM_W   = 16;
   localparam logic [15:0] NORM_ONE = 16'h8000;
   localparam logic [15:0] NORM_HALF = 16'h4000;
   localparam int          FRAC_W   = 16;        // gain fraction bits
   localparam int          ACC_W    = 50;

   // ==========================================================
   // sources
   // ==========================================================
   localparam int          NSRC     = 8;
   localparam int          SEL_W    = 4;
   localparam logic [3:0]  SEL_NONE = 4'h0;      // not connected
   localparam int          NCHAN    = 3;
   localparam int          CH_SP    = 0;
   localparam int          CH_FB    = 1;
   localparam int          CH_RST   = 2;

   // ==========================================================
   // timing
   // ==========================================================
   localparam longint      CLK_KHZ      = 250000;
   localparam longint      TS_MIN_MS    = 1;     // 0.001 s
   localparam longint      TS_MAX_MS    = 10000; // 10 s
   localparam logic [31:0] TS_MIN_CYC   = 32'(TS_MIN_MS * CLK_KHZ);
   localparam logic [31:0] TS_MAX_CYC   = 32'(TS_MAX_MS * CLK_KHZ);

   // ==========================================================
   // register map (byte addresses)
   // ==========================================================
   localparam logic [7:0]  A_CTRL   = 8'h00;
   localparam logic [7:0]  A_SRC    = 8'h04;
   localparam logic [7:0]  A_MANUAL = 8'h08;
   localparam logic [7:0]  A_PGAIN  = 8'h0C;
   localparam logic [7:0]  A_KI     = 8'h10;
   localparam logic [7:0]  A_KD     = 8'h14;
   localparam logic [7:0]  A_PERIOD = 8'h18;
   localparam logic [7:0]  A_STATUS = 8'h1C;
   localparam logic [7:0]  A_INTEG  = 8'h20;

   // ctrl fields
   localparam int          B_SP_INV  = 0;
   localparam int          B_FB_INV  = 1;
   localparam int          B_RST_INV = 2;
   localparam int          B_MANUAL  = 3;
   // src fields: channel n at [4n+3:4n]
   // status fields
   localparam int          B_ST_FREEZE = 16;
   localparam int          B_ST_RESET  = 17;
   localparam int          B_ST_UNCON  = 18;
   localparam int          B_ST_MANUAL = 19;

   // reset values
   localparam logic [3:0]  RV_CTRL   = 4'h0;
   localparam logic [11:0] RV_SRC    = 12'h000;
   localparam logic [15:0] RV_MANUAL = NORM_HALF;
   localparam logic [31:0] RV_PGAIN  = 32'h0001_0000; // 1.0
   localparam logic [31:0] RV_KI     = 32'h0000_028F; // 0.001/0.1
   localparam logic [31:0] RV_KD     = 32'h000A_0000; // 0.01/0.001

   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  HRESP_OKAY    = 2'h0;

endpackage : prb_pkg

// file: verilog/prb_input_sel.sv
// source selection and inversion for one regulator input
`timescale 1ns/100ps
module prb_input_sel (
   input  wire logic [prb_pkg::NSRC*prb_pkg::NORM_W-1:0] src_bus_i,
   input  wire logic [prb_pkg::SEL_W-1:0]               sel_i,
   input  wire logic                                    invert_i,
   output logic      [prb_pkg::NORM_W-1:0]              value_o,
   output logic                                         connected_o
);

   logic [prb_pkg::NORM_W-1:0] raw;
   logic [prb_pkg::NORM_W-1:0] clamped;
   logic [prb_pkg::SEL_W-1:0]  idx;

   always_comb begin
      idx         = sel_i - 4'h1;
      connected_o = (sel_i != prb_pkg::SEL_NONE) && (sel_i <= 4'(prb_pkg::NSRC));
      raw         = connected_o ? src_bus_i[idx*prb_pkg::NORM_W +: prb_pkg::NORM_W] : 16'h0000;
      // out-of-range source words are taken as full scale
      clamped     = (raw > prb_pkg::NORM_ONE) ? prb_pkg::NORM_ONE : raw;
      if (!connected_o) begin
         value_o = 16'h0000;
      end else if (invert_i) begin
         value_o = prb_pkg::NORM_ONE - clamped;
      end else begin
         value_o = clamped;
      end
   end

endmodule : prb_input_sel

// file: verilog/prb_period_timer.sv
// control period tick generator
`timescale 1ns/100ps
module prb_period_timer (
   input  wire logic        clk_i,
   input  wire logic        sys_rst_i,
   input  wire logic [31:0] period_i,
   output logic             tick_o
);

   logic [31:0] cnt_r;

   // a shortened period takes effect at once instead of waiting out the old one
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         cnt_r  <= 32'h0000_0000;
         tick_o <= 1'b0;
      end else if (cnt_r >= period_i - 32'h1) begin
         cnt_r  <= 32'h0000_0000;
         tick_o <= 1'b1;
      end else begin
         cnt_r  <= cnt_r + 32'h1;
         tick_o <= 1'b0;
      end
   end

endmodule : prb_period_timer

// file: verilog/prb_regulator.sv
// pid regulator block: ahb-lite registers, input selection and the pid datapath
// Overview of operation
// - The output is the computed value clipped to the range zero to one.
// - The unclipped value is gain times (error plus integral over Ti minus Td times process rate).
// - The error is the selected setpoint value minus the process value.
// - The process value for error and derivative comes from the selected feedback input.
// - Setpoint, feedback and reset inputs each have their own inversion flag, off by default.
// - The integrator stops while the output is above one with positive error or below zero with negative error.
// - While the reset value is at or above one half the integrator is zero and, outside manual mode, the output is zero.
// - Manual mode, off by default, replaces the regulated output by the manual value.
// - The manual value is settable within zero to one and defaults to one half.
// - The derivative is taken from the process value only, never from the error.
// - One update is made per control period, settable from 0.001 s to 10 s, default 0.001 s.
// - Each input selects any source output or none, and all start unconnected.
//
// Local design decisions: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
module prb_regulator #(
   parameter logic [31:0] DEFAULT_PERIOD_CYCLES = prb_pkg::TS_MIN_CYC
) (
   input  wire logic                                    clk_i,
   input  wire logic                                    sys_rst_i,
   // ahb-lite slave
   input  wire logic                                    hsel_i,
   input  wire logic [31:0]                             haddr_i,
   input  wire logic [1:0]                              htrans_i,
   input  wire logic                                    hwrite_i,
   input  wire logic [2:0]                              hsize_i,
   input  wire logic [31:0]                             hwdata_i,
   input  wire logic                                    hready_i,
   output logic      [31:0]                             hrdata_o,
   output logic                                         hreadyout_o,
   output logic      [1:0]                              hresp_o,
   // logical outputs of other blocks
   input  wire logic [prb_pkg::NSRC*prb_pkg::NORM_W-1:0] src_bus_i,
   // regulator result
   output logic      [prb_pkg::NORM_W-1:0]              norm_regulator_output_o,
   output logic                                         update_o
);

   // ==========================================================
   // configuration registers
   // ==========================================================
   logic [3:0]  ctrl_r;
   logic [11:0] src_r;
   logic [15:0] manual_r;
   logic [31:0] pgain_r;
   logic [31:0] ki_r;
   logic [31:0] kd_r;
   logic [31:0] period_r;

   logic        wr_pend_r;
   logic [7:0]  wr_addr_r;
   logic        addr_ok;
   logic [31:0] rd_nxt;
   logic [31:0] wdata_period;
   logic [15:0] wdata_manual;

   // ==========================================================
   // regulator state
   // ==========================================================
   logic signed [prb_pkg::ACC_W-1:0] acc_r;
   logic [15:0]                      pv_prev_r;
   logic                             freeze_r;
   logic                             idle_r;

   logic [15:0] chan_val [prb_pkg::NCHAN];
   logic        chan_con [prb_pkg::NCHAN];
   logic [15:0] norm_setpoint_value;
   logic [15:0] norm_process_value;
   logic [15:0] norm_reset_value;
   logic        tick;
   logic        reset_act;
   logic        uncon;
   logic        manual_en;

   logic signed [16:0] err;
   logic signed [16:0] dpv;
   logic signed [49:0] ki_term;
   logic signed [49:0] kd_term;
   logic signed [55:0] sum;
   logic signed [88:0] prod;
   logic               y_neg;
   logic               y_over;
   logic               y_sat;
   logic               freeze;
   logic [15:0]        y_clip;
   logic [15:0]        out_nxt;

   localparam logic signed [88:0] PROD_ONE = 89'sh8000_0000_0000; // 1.0 in product units

   function automatic logic [31:0] clamp_period(input logic [31:0] v);
      if (v < prb_pkg::TS_MIN_CYC) begin
         return prb_pkg::TS_MIN_CYC;
      end else if (v > prb_pkg::TS_MAX_CYC) begin
         return prb_pkg::TS_MAX_CYC;
      end
      return v;
   endfunction : clamp_period

   // ==========================================================
   // ahb-lite slave: zero wait states, always okay
   // ==========================================================
   assign hreadyout_o  = 1'b1;
   assign hresp_o      = prb_pkg::HRESP_OKAY;
   assign addr_ok      = hsel_i && hready_i && (htrans_i == prb_pkg::HTRANS_NONSEQ);
   assign wdata_period = clamp_period(hwdata_i);
   assign wdata_manual = (hwdata_i[15:0] > prb_pkg::NORM_ONE) ? prb_pkg::NORM_ONE : hwdata_i[15:0];

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
      end else begin
         wr_pend_r <= addr_ok && hwrite_i && (haddr_i[31:8] == 24'h00_0000);
         wr_addr_r <= haddr_i[7:0];
      end
   end

   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (haddr_i[31:8] == 24'h00_0000) begin
         case (haddr_i[7:0])
            prb_pkg::A_CTRL:   rd_nxt = {28'h000_0000, ctrl_r};
            prb_pkg::A_SRC:    rd_nxt = {20'h0_0000, src_r};
            prb_pkg::A_MANUAL: rd_nxt = {16'h0000, manual_r};
            prb_pkg::A_PGAIN:  rd_nxt = pgain_r;
            prb_pkg::A_KI:     rd_nxt = ki_r;
            prb_pkg::A_KD:     rd_nxt = kd_r;
            prb_pkg::A_PERIOD: rd_nxt = period_r;
            prb_pkg::A_STATUS: rd_nxt = {12'h000, manual_en, uncon, reset_act, freeze_r, norm_regulator_output_o};
            prb_pkg::A_INTEG:  rd_nxt = acc_r[prb_pkg::ACC_W-1 -: 32];
            default:           rd_nxt = 32'h0000_0000;
         endcase
      end
   end

   // read data is captured at the address phase so it stands through the data phase
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         hrdata_o <= 32'h0000_0000;
      end else if (addr_ok && !hwrite_i) begin
         hrdata_o <= rd_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ctrl_r   <= prb_pkg::RV_CTRL;
         src_r    <= prb_pkg::RV_SRC;
         manual_r <= prb_pkg::RV_MANUAL;
         pgain_r  <= prb_pkg::RV_PGAIN;
         ki_r     <= prb_pkg::RV_KI;
         kd_r     <= prb_pkg::RV_KD;
         period_r <= clamp_period(DEFAULT_PERIOD_CYCLES);
      end else if (wr_pend_r) begin
         case (wr_addr_r)
            prb_pkg::A_CTRL:   ctrl_r   <= hwdata_i[3:0];
            prb_pkg::A_SRC:    src_r    <= hwdata_i[11:0];
            prb_pkg::A_MANUAL: manual_r <= wdata_manual;
            prb_pkg::A_PGAIN:  pgain_r  <= hwdata_i;
            prb_pkg::A_KI:     ki_r     <= hwdata_i;
            prb_pkg::A_KD:     kd_r     <= hwdata_i;
            prb_pkg::A_PERIOD: period_r <= wdata_period;
            default:           ctrl_r   <= ctrl_r;
         endcase
      end
   end

   // ==========================================================
   // inputs
   // ==========================================================
   genvar ch;
   generate
      for (ch = 0; ch < prb_pkg::NCHAN; ch++) begin : g_chan
         prb_input_sel u_sel (
            .src_bus_i   (src_bus_i),
            .sel_i       (src_r[ch*prb_pkg::SEL_W +: prb_pkg::SEL_W]),
            .invert_i    (ctrl_r[ch]),
            .value_o     (chan_val[ch]),
            .connected_o (chan_con[ch])
         );
      end
   endgenerate

   assign norm_setpoint_value = chan_val[prb_pkg::CH_SP];
   assign norm_process_value  = chan_val[prb_pkg::CH_FB];
   // an unconnected reset input is never active, even when inverted
   assign norm_reset_value    = chan_con[prb_pkg::CH_RST] ? chan_val[prb_pkg::CH_RST] : 16'h0000;
   assign reset_act           = norm_reset_value >= prb_pkg::NORM_HALF;
   assign uncon               = !chan_con[prb_pkg::CH_SP] || !chan_con[prb_pkg::CH_FB];
   assign manual_en           = ctrl_r[prb_pkg::B_MANUAL];

   prb_period_timer u_timer (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .period_i  (period_r),
      .tick_o    (tick)
   );

   // ==========================================================
   // pid datapath, evaluated against the integrator before update
   // ==========================================================
   always_comb begin
      err     = $signed({1'b0, norm_setpoint_value}) - $signed({1'b0, norm_process_value});
      dpv     = $signed({1'b0, norm_process_value}) - $signed({1'b0, pv_prev_r});
      ki_term = 50'(err) * 50'($signed({1'b0, ki_r}));
      kd_term = 50'(dpv) * 50'($signed({1'b0, kd_r}));
      sum     = $signed({{23{err[16]}}, err, 16'h0000})
              + $signed({{6{acc_r[prb_pkg::ACC_W-1]}}, acc_r})
              - $signed({{6{kd_term[49]}}, kd_term});
      prod    = 89'(sum) * 89'($signed({1'b0, pgain_r}));
      y_neg   = prod < 89'sh0;
      y_over  = prod > PROD_ONE;
      y_sat   = prod >= PROD_ONE;
      freeze  = (y_over && (err > 17'sh0)) || (y_neg && (err < 17'sh0));
      if (y_neg) begin
         y_clip = 16'h0000;
      end else if (y_sat) begin
         y_clip = prb_pkg::NORM_ONE;
      end else begin
         y_clip = prod[47:32];
      end
   end

   // manual wins over reset and missing sources, which only act on the integrator then
   always_comb begin
      if (manual_en) begin
         out_nxt = manual_r;
      end else if (reset_act || uncon) begin
         out_nxt = 16'h0000;
      end else if (tick) begin
         out_nxt = y_clip;
      end else begin
         out_nxt = norm_regulator_output_o;
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         norm_regulator_output_o <= 16'h0000;
         update_o                <= 1'b0;
      end else begin
         norm_regulator_output_o <= out_nxt;
         update_o                <= tick;
      end
   end

   // integrator; no wrap guard beyond anti-windup, gains are kept sane by software
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         acc_r <= '0;
      end else if (reset_act || uncon) begin
         acc_r <= '0;
      end else if (tick && !manual_en && !freeze) begin
         acc_r <= acc_r + ki_term;
      end
   end

   // keeping the previous sample current while idle avoids a derivative kick on restart;
   // the extra idle cycle picks up a freshly connected feedback source
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         pv_prev_r <= 16'h0000;
         freeze_r  <= 1'b0;
         idle_r    <= 1'b1;
      end else begin
         idle_r <= reset_act || uncon || manual_en;
         if (tick || idle_r || reset_act || uncon || manual_en) begin
            pv_prev_r <= norm_process_value;
         end
         if (tick) begin
            freeze_r <= freeze && !manual_en && !reset_act && !uncon;
         end
      end
   end

endmodule : prb_regulator

// file: sim/prb_src_model.sv
// model of the other functional blocks feeding the regulator inputs
`timescale 1ns/100ps
module prb_src_model (
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         wr_en_i,
   input  wire logic [2:0]   wr_idx_i,
   input  wire logic [15:0]  wr_val_i,
   output logic      [127:0] src_bus_o
);
   // outputs of other blocks change only at a clock edge, as the real ones do
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_bus_o <= '0;
      end else if (wr_en_i) begin
         src_bus_o[16*wr_idx_i +: 16] <= wr_val_i;
      end
   end
endmodule : prb_src_model

// file: sim/prb_regulator_props.sv
// checker of the pid regulator block port behaviour
`timescale 1ns/100ps
module prb_regulator_props #(
   parameter logic [31:0] DEFAULT_PERIOD_CYCLES = prb_pkg::TS_MIN_CYC
) (
   input wire logic         clk_i,
   input wire logic         sys_rst_i,
   input wire logic         hsel_i,
   input wire logic [31:0]  haddr_i,
   input wire logic [1:0]   htrans_i,
   input wire logic         hwrite_i,
   input wire logic [2:0]   hsize_i,
   input wire logic [31:0]  hwdata_i,
   input wire logic         hready_i,
   input wire logic [31:0]  hrdata_o,
   input wire logic         hreadyout_o,
   input wire logic [1:0]   hresp_o,
   input wire logic [127:0] src_bus_i,
   input wire logic [15:0]  norm_regulator_output_o,
   input wire logic         update_o
);
   // ==========================================
   // shadow of the ctrl, source and manual fields
   // ==========================================
   localparam logic [31:0] MIN_GAP = prb_pkg::TS_MIN_CYC - 32'h1;
   logic        take, wr_r, rst_act, uncon;
   logic [7:0]  adr_r;
   logic [3:0]  ctrl_r;
   logic [11:0] src_r;
   logic [15:0] man_r;
   logic [31:0] gap_r;
   function automatic logic on(input logic [3:0] s);
      return s >= 4'h1 && s <= 4'h8;
   endfunction : on
   function automatic logic [15:0] val(input logic [127:0] b, input logic [3:0] s, input logic inv);
      logic [15:0] w;
      w = on(s) ? b[16*(int'(s)-1) +: 16] : 16'h0;
      w = (w > prb_pkg::NORM_ONE) ? prb_pkg::NORM_ONE : w;
      return inv ? prb_pkg::NORM_ONE - w : w;
   endfunction : val
   assign take = hsel_i & hready_i & (htrans_i == prb_pkg::HTRANS_NONSEQ);
   assign rst_act = on(src_r[11:8]) && (val(src_bus_i, src_r[11:8], ctrl_r[2]) >= prb_pkg::NORM_HALF);
   assign uncon = !on(src_r[3:0]) || !on(src_r[7:4]);
   always_ff @(posedge clk_i) begin
      wr_r  <= take & hwrite_i & (haddr_i[31:8] == 24'h0);
      adr_r <= haddr_i[7:0];
   end
   // writes land on the data-phase edge, same as the design registers
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ctrl_r <= prb_pkg::RV_CTRL;
         src_r  <= prb_pkg::RV_SRC;
         man_r  <= prb_pkg::RV_MANUAL;
      end else if (wr_r) begin
         if (adr_r == prb_pkg::A_CTRL) ctrl_r <= hwdata_i[3:0];
         if (adr_r == prb_pkg::A_SRC) src_r <= hwdata_i[11:0];
         if (adr_r == prb_pkg::A_MANUAL) man_r <= (hwdata_i[15:0] > prb_pkg::NORM_ONE) ? prb_pkg::NORM_ONE
            : hwdata_i[15:0];
      end
   end
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) gap_r <= 32'h0;
      else if (update_o) gap_r <= 32'h1;
      else gap_r <= gap_r + 32'h1;
   end
   // ==========================================
   // properties
   // ==========================================
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   sequence s_rst_held;
      (rst_act && !ctrl_r[3]) [*2];
   endsequence
   sequence s_uncon_held;
      (uncon && !ctrl_r[3]) [*2];
   endsequence
   sequence s_man_held;
      (ctrl_r[3] && $stable(man_r)) [*2];
   endsequence
   sequence s_read(logic [7:0] a);
      take && !hwrite_i && (haddr_i == {24'h0, a});
   endsequence
   a_out_bounded: assert property (norm_regulator_output_o <= prb_pkg::NORM_ONE)
      else $error("output above one");
   a_upd_pulse: assert property (update_o |=> !update_o)
      else $error("update longer than one cycle");
   a_upd_spacing: assert property (update_o |-> gap_r >= MIN_GAP)
      else $error("updates closer than the control period");
   a_rst_zero: assert property (s_rst_held |-> norm_regulator_output_o == 16'h0)
      else $error("output not zero under reset input");
   a_uncon_zero: assert property (s_uncon_held |-> norm_regulator_output_o == 16'h0)
      else $error("output not zero while unconnected");
   a_manual_out: assert property (s_man_held |-> norm_regulator_output_o == man_r)
      else $error("manual output differs from manual value");
   a_read_manual: assert property (s_read(prb_pkg::A_MANUAL) |=> hrdata_o == {16'h0, $past(man_r)})
      else $error("manual value read back wrong");
   a_read_src: assert property (s_read(prb_pkg::A_SRC) |=> hrdata_o == {20'h0, $past(src_r)})
      else $error("source selection read back wrong");
   a_read_ctrl: assert property (s_read(prb_pkg::A_CTRL) |=> hrdata_o == {28'h0, $past(ctrl_r)})
      else $error("control flags read back wrong");
   a_bus_okay: assert property (hreadyout_o && hresp_o == prb_pkg::HRESP_OKAY)
      else $error("bus not ready or not okay");
   a_wake_quiet: assert property ($past(sys_rst_i) |-> norm_regulator_output_o == 16'h0 && !update_o)
      else $error("output active right after reset");
endmodule : prb_regulator_props
bind prb_regulator prb_regulator_props #(.DEFAULT_PERIOD_CYCLES(DEFAULT_PERIOD_CYCLES)) prb_regulator_props_inst (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
   .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .src_bus_i(src_bus_i),
   .norm_regulator_output_o(norm_regulator_output_o), .update_o(update_o));

// file: sim/tb.sv
// self-checking testbench of the pid regulator block
`timescale 1ns/100ps
module tb;
   // ==========================================
   // signals and design
   // ==========================================
   localparam int LIMIT = 600000;
   localparam logic [7:0]  DEF_A [9] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20, 8'h40};
   localparam logic [31:0] DEF_V [9] = '{32'h0, 32'h0, 32'h4000, 32'h1_0000, 32'h28F, 32'hA_0000,
                                          32'h4_0000, 32'h0, 32'h0};
   logic         clk_i, sys_rst_i, hsel_i, hwrite_i, hreadyout_o, update_o, src_we;
   logic [1:0]   htrans_i, hresp_o;
   logic [2:0]   hsize_i, src_idx;
   logic [15:0]  src_val, out_w, sp, pv;
   logic [31:0]  haddr_i, hwdata_i, hrdata_o, rd;
   logic [127:0] src_bus;
   integer       seed;
   int           miscompares = 0;
   int           check_count = 0;
   int           cycles = 0;
   prb_regulator #(.DEFAULT_PERIOD_CYCLES(prb_pkg::TS_MIN_CYC)) prb_regulator_inst (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
      .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .src_bus_i(src_bus),
      .norm_regulator_output_o(out_w), .update_o(update_o));
   prb_src_model prb_src_model_inst (.clk_i(clk_i), .rst_i(sys_rst_i), .wr_en_i(src_we),
      .wr_idx_i(src_idx), .wr_val_i(src_val), .src_bus_o(src_bus));
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // ==========================================
   // tasks and expectations
   // ==========================================
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   // address phase held until hready, then data phase until hready again
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      htrans_i <= prb_pkg::HTRANS_NONSEQ;
      haddr_i  <= a;
      hwrite_i <= w;
      hsel_i   <= 1'b1;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      htrans_i <= 2'h0;
      hsel_i   <= 1'b0;
      hwdata_i <= d;
      do @(posedge clk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, {24'h0, a}, d);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      bus(1'b0, {24'h0, a}, 32'h0);
      check(rd, e);
   endtask : rchk
   task automatic set_src(input logic [2:0] i, input logic [15:0] v);
      src_idx <= i;
      src_val <= v;
      src_we  <= 1'b1;
      @(posedge clk_i);
      src_we  <= 1'b0;
      @(posedge clk_i);
   endtask : set_src
   task automatic wait_update();
      do @(posedge clk_i); while (update_o !== 1'b1);
   endtask : wait_update
   function automatic logic [15:0] norm(input logic [15:0] w, input logic inv);
      logic [15:0] c;
      c = (w > 16'h8000) ? 16'h8000 : w;
      return inv ? 16'h8000 - c : c;
   endfunction : norm
   function automatic logic [31:0] exp_out(input logic [31:0] p, input logic [15:0] s, input logic [15:0] f);
      longint y;
      y = (longint'(p) * (longint'(s) - longint'(f))) >>> 16;
      if (y < 0) return 32'h0;
      if (y > 32768) return 32'h8000;
      return 32'(y);
   endfunction : exp_out
   // bound on the whole run; two control periods plus bus traffic
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         $display("mismatch at %0t: timeout", $time);
         end_of_test();
      end
   end
   // ==========================================
   // scenarios
   // ==========================================
   initial begin
      seed = 32'hC0DB424E;
      sys_rst_i = 1'b1;
      hsize_i = 3'h2;
      {hsel_i, hwrite_i, src_we, htrans_i, src_idx, src_val, haddr_i, hwdata_i} = '0;
      repeat (20) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      check(32'(out_w), 32'h0);
      wr(prb_pkg::A_STATUS, 32'hFFFF_FFFF);
      wr(8'h40, 32'hFFFF_FFFF);
      foreach (DEF_A[i]) rchk(DEF_A[i], DEF_V[i]);
      bus(1'b0, 32'h0000_0100, 32'h0);
      check(rd, 32'h0);
      wr(prb_pkg::A_PERIOD, 32'h10);
      rchk(prb_pkg::A_PERIOD, prb_pkg::TS_MIN_CYC);
      wr(prb_pkg::A_PERIOD, 32'hFFFF_FFFF);
      rchk(prb_pkg::A_PERIOD, prb_pkg::TS_MAX_CYC);
      wr(prb_pkg::A_PERIOD, prb_pkg::TS_MIN_CYC);
      $display("test defaults done");
      sp = 16'($random(seed)) & 16'h7FFF;
      wr(prb_pkg::A_MANUAL, {16'h0, sp});
      wr(prb_pkg::A_CTRL, 32'h8);
      repeat (3) @(posedge clk_i);
      check(32'(out_w), 32'(sp));
      wr(prb_pkg::A_MANUAL, 32'h0000_FFFF);
      rchk(prb_pkg::A_MANUAL, 32'h0000_8000);
      check(32'(out_w), 32'h0000_8000);
      wr(prb_pkg::A_CTRL, 32'h0);
      $display("test manual done");
      wr(prb_pkg::A_KI, 32'h0);
      wr(prb_pkg::A_KD, 32'h0);
      wr(prb_pkg::A_PGAIN, 32'h0001_8000);
      sp = 16'($random(seed)) & 16'h7FFF;
      pv = 16'($random(seed)) & 16'h7FFF;
      set_src(3'h0, sp);
      set_src(3'h1, pv);
      wr(prb_pkg::A_SRC, 32'h0000_0021);
      wait_update();
      check(32'(out_w), exp_out(32'h0001_8000, sp, pv));
      // small setpoint: inverted error drives the output past one
      sp = 16'($random(seed)) & 16'h1FFF;
      set_src(3'h0, sp);
      set_src(3'h1, 16'hFFFF);
      wr(prb_pkg::A_PGAIN, 32'h0004_0000);
      wr(prb_pkg::A_CTRL, 32'h3);
      wait_update();
      check(32'(out_w), exp_out(32'h0004_0000, norm(sp, 1'b1), norm(16'hFFFF, 1'b1)));
      bus(1'b0, {24'h0, prb_pkg::A_STATUS}, 32'h0);
      check(32'(rd[prb_pkg::B_ST_FREEZE]), 32'h1);
      $display("test regulation done");
      set_src(3'h2, 16'h1000);
      wr(prb_pkg::A_SRC, 32'h0000_0321);
      wr(prb_pkg::A_CTRL, 32'h7);
      repeat (2) @(posedge clk_i);
      check(32'(out_w), 32'h0);
      rchk(prb_pkg::A_INTEG, 32'h0);
      for (int i = 0; i < 2; i++) begin
         set_src(3'h2, 16'h3FFF + 16'(i));
         wr(prb_pkg::A_CTRL, 32'h3);
         bus(1'b0, {24'h0, prb_pkg::A_STATUS}, 32'h0);
         check(32'(rd[prb_pkg::B_ST_RESET]), 32'(i));
      end
      $display("test reset input done");
      end_of_test();
   end
endmodule : tb
